// *** core/sir_defines.vh ***
// Constants for the system reset and break control block.
// Assumes plain Verilog-2005 and inclusion by bare name.
`ifndef SIR_DEFINES_VH
`define SIR_DEFINES_VH
// Register byte addresses
`define SIR_ADDR_BRK_STAT 16'hfe00
`define SIR_ADDR_RST_CAUSE 16'hfe01
`define SIR_ADDR_BRK_CTRL 16'hfe03
`define SIR_ADDR_IRQ_STAT 16'hfe08
`define SIR_ADDR_IRQ_MASK 16'hfe0c
`define SIR_ADDR_WDOG_SVC 16'hffff
// Field positions
`define SIR_BIT_SWB 1
`define SIR_BIT_BREAK_CLEAR_ENABLE 7
`define SIR_BIT_POR 7
`define SIR_BIT_PIN 6
`define SIR_BIT_WDOG 5
`define SIR_BIT_ILLEGAL_OPCODE_CAUSE 4
// Interrupt status bits
`define SIR_IRQ_WDOG 0
`define SIR_IRQ_ILLEGAL_OPCODE_CAUSE 1
`define SIR_IRQ_PIN 2
`define SIR_IRQ_SWI 3
// Reset values and timing
`define SIR_ZERO8 8'h00
`define SIR_POR_CAUSE 8'h80
`define SIR_STAB_CYCLES 4096
`define SIR_PRE_W 13
`define SIR_PRE_HI 12
`define SIR_PRE_LO 5
`define SIR_PRE_TOP 13'h1ff0
`define SIR_WDOG_W 8
`define SIR_RSTOUT_CYCLES 32
// AXI responses
`define SIR_RESP_OKAY 2'b00
`define SIR_RESP_SLVERR 2'b10
`endif

// *** core/sir_top.v ***
// System reset, watchdog, break flag and interrupt entry control.
// Assumes one clock, AXI4-Lite master, core strobes on clk_sys.
//
// What this block does
// - At power-on pulse a reset, assert internal reset, enable base clock output.
// - Hold core and module clocks inactive for 4096 oscillator cycles after power-on.
// - Drive reset pin low throughout the stabilisation interval.
// - Power-on reset sets power-on cause and clears all other cause bits.
// - Watchdog overflow makes internal reset and sets the watchdog cause flag.
// - Every internal reset source pulls the reset pin low.
// - Any write to service address clears watchdog and prescale bits 12 to 5.
// - Prescale output ticks the watchdog at least every 2^13 minus 2^4 cycles.
// - Monitor mode with high voltage on reset or interrupt_one_pin pin disables the watchdog.
// - In break, high voltage on the reset pin disables the watchdog.
// - Illegal instruction sets illegal-opcode cause and causes a reset.
// - Software interrupt ignores mask and stacks current PC, not PC minus one.
// - Interrupt entry does not push the high index register.
// - Writing zero to stop/wait break indicator clears it.
// - Clear-enable set lets flags clear in break; they stay cleared after.
// - Clear-enable clear freezes flags in break; two-step clear finishes after.
// - Interrupt status flags show which maskable source is pending.
`timescale 1ns/1ps
`include "sir_defines.vh"

module sir_top #(
  parameter STAB_CYCLES = `SIR_STAB_CYCLES,
  parameter WDOG_W = `SIR_WDOG_W
) (
  input wire clk_sys,
  input wire rst,
  // AXI4-Lite slave
  input wire [15:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [15:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Pins and core
  input wire rst_pin_in,
  output reg rst_pin_out,
  output reg rst_pin_oe,
  input wire rst_pin_hv,
  input wire interrupt_one_pin_pin_hv,
  input wire interrupt_one_pin_req,
  input wire monitor_mode,
  input wire break_active,
  input wire stop_wait_in_break,
  input wire illegal_opcode,
  input wire swi_exec,
  input wire hw_irq_req,
  input wire int_mask,
  input wire [15:0] core_pc,
  input wire flag_clear_req,
  output reg flag_clear_allow,
  output reg base_clk_en,
  output reg core_clk_en,
  output reg sys_reset,
  output reg int_take,
  output reg [15:0] int_stack_pc,
  output reg int_push_hx,
  output reg irq_out
);

  // ****************************************
  // Local state
  // ****************************************
  localparam ST_POR = 2'd0;
  localparam ST_STAB = 2'd1;
  localparam ST_RUN = 2'd2;
  localparam ST_IRST = 2'd3;

  reg [1:0] state_q;
  reg [12:0] stab_cnt_q;
  reg [12:0] pre_q;
  reg [WDOG_W-1:0] wdog_q;
  reg [5:0] rout_cnt_q;
  reg [7:0] cause_q;
  reg swb_q;
  reg break_clear_enable_q;
  reg [3:0] irq_stat_q;
  reg [3:0] irq_mask_q;
  reg [1:0] rpin_sync_q;
  reg [1:0] rhv_sync_q;
  reg [1:0] ihv_sync_q;
  reg [1:0] interrupt_one_pin_sync_q;
  reg rpin_prev_q;
  reg [15:0] awaddr_q;
  reg aw_have_q;
  reg [31:0] wdata_q;
  reg w_have_q;

  // ****************************************
  // Functions
  // ****************************************
  function hit;
    input [15:0] a;
    input [15:0] b;
    begin
      hit = (a == b);
    end
  endfunction

  // ****************************************
  // Bus capture and strobes
  // ****************************************
  wire wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;
  wire rd_fire = s_axi_arvalid && s_axi_arready;
  wire wr_svc = wr_fire && hit(awaddr_q, `SIR_ADDR_WDOG_SVC);
  wire wr_bstat = wr_fire && hit(awaddr_q, `SIR_ADDR_BRK_STAT);
  wire wr_bctrl = wr_fire && hit(awaddr_q, `SIR_ADDR_BRK_CTRL);
  wire wr_imask = wr_fire && hit(awaddr_q, `SIR_ADDR_IRQ_MASK);
  wire wr_known = wr_svc || wr_bstat || wr_bctrl || wr_imask ||
    hit(awaddr_q, `SIR_ADDR_RST_CAUSE) || hit(awaddr_q, `SIR_ADDR_IRQ_STAT);
  wire rd_istat = rd_fire && hit(s_axi_araddr, `SIR_ADDR_IRQ_STAT);
  // Flags frozen in break unless clear-enable is set
  wire clr_ok = !break_active || break_clear_enable_q;

  // ****************************************
  // Synchronisers and watchdog disable
  // ****************************************
  wire hv_rst = rhv_sync_q[1];
  wire hv_irq = ihv_sync_q[1];
  wire wdog_off = (monitor_mode && (hv_rst || hv_irq)) ||
    (break_active && hv_rst);
  wire pre_tick = (pre_q == `SIR_PRE_TOP);
  wire wdog_ovf = pre_tick && (&wdog_q) && !wdog_off && (state_q == ST_RUN);
  wire illegal_opcode_cause_ev = illegal_opcode && (state_q == ST_RUN);
  wire pin_ev = rpin_prev_q && !rpin_sync_q[1] && !rst_pin_oe && (state_q == ST_RUN);
  wire [3:0] irq_ev;
  assign irq_ev[`SIR_IRQ_WDOG] = wdog_ovf;
  assign irq_ev[`SIR_IRQ_ILLEGAL_OPCODE_CAUSE] = illegal_opcode_cause_ev;
  assign irq_ev[`SIR_IRQ_PIN] = interrupt_one_pin_sync_q[1];
  assign irq_ev[`SIR_IRQ_SWI] = swi_exec;

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rpin_sync_q <= 2'b11;
      rhv_sync_q <= 2'b00;
      ihv_sync_q <= 2'b00;
      interrupt_one_pin_sync_q <= 2'b00;
      rpin_prev_q <= 1'b1;
    end else begin
      rpin_sync_q <= {rpin_sync_q[0], rst_pin_in};
      rhv_sync_q <= {rhv_sync_q[0], rst_pin_hv};
      ihv_sync_q <= {ihv_sync_q[0], interrupt_one_pin_pin_hv};
      interrupt_one_pin_sync_q <= {interrupt_one_pin_sync_q[0], interrupt_one_pin_req};
      rpin_prev_q <= rpin_sync_q[1];
    end
  end

  // ****************************************
  // Reset sequencer, counters, cause
  // ****************************************
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_q <= ST_POR;
      stab_cnt_q <= 13'h0000;
      pre_q <= 13'h0000;
      wdog_q <= {WDOG_W{1'b0}};
      rout_cnt_q <= 6'h00;
      cause_q <= `SIR_POR_CAUSE;
      sys_reset <= 1'b1;
      base_clk_en <= 1'b0;
      core_clk_en <= 1'b0;
      rst_pin_out <= 1'b0;
      rst_pin_oe <= 1'b1;
    end else begin
      case (state_q)
        ST_POR: begin
          base_clk_en <= 1'b1;
          state_q <= ST_STAB;
          stab_cnt_q <= 13'h0000;
        end
        ST_STAB: begin
          rst_pin_oe <= 1'b1;
          core_clk_en <= 1'b0;
          if (stab_cnt_q == STAB_CYCLES - 1) begin
            state_q <= ST_RUN;
            sys_reset <= 1'b0;
            core_clk_en <= 1'b1;
            rst_pin_oe <= 1'b0;
            pre_q <= 13'h0000;
            wdog_q <= {WDOG_W{1'b0}};
          end else begin
            stab_cnt_q <= stab_cnt_q + 13'h0001;
          end
        end
        ST_RUN: begin
          if (wdog_ovf || illegal_opcode_cause_ev) begin
            state_q <= ST_IRST;
            sys_reset <= 1'b1;
            rst_pin_oe <= 1'b1;
            rout_cnt_q <= 6'h00;
            // Newest cause only
            cause_q <= wdog_ovf ? (8'h01 << `SIR_BIT_WDOG) : (8'h01 << `SIR_BIT_ILLEGAL_OPCODE_CAUSE);
          end else if (pin_ev) begin
            state_q <= ST_IRST;
            sys_reset <= 1'b1;
            rout_cnt_q <= 6'h00;
            cause_q <= 8'h01 << `SIR_BIT_PIN;
          end else begin
            if (wr_svc) begin
              wdog_q <= {WDOG_W{1'b0}};
              pre_q[`SIR_PRE_HI:`SIR_PRE_LO] <= 8'h00;
            end else begin
              pre_q <= pre_tick ? 13'h0000 : pre_q + 13'h0001;
              if (pre_tick && !wdog_off) begin
                wdog_q <= wdog_q + 1'b1;
              end
            end
          end
        end
        ST_IRST: begin
          if (rout_cnt_q == `SIR_RSTOUT_CYCLES - 1) begin
            state_q <= ST_RUN;
            sys_reset <= 1'b0;
            rst_pin_oe <= 1'b0;
            pre_q <= 13'h0000;
            wdog_q <= {WDOG_W{1'b0}};
          end else begin
            rout_cnt_q <= rout_cnt_q + 6'h01;
          end
        end
        default: begin
          state_q <= ST_POR;
        end
      endcase
    end
  end

  // ****************************************
  // Break, interrupt flags, interrupt entry
  // ****************************************
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      swb_q <= 1'b0;
      break_clear_enable_q <= 1'b0;
      irq_stat_q <= 4'h0;
      irq_mask_q <= 4'h0;
      irq_out <= 1'b0;
      flag_clear_allow <= 1'b0;
      int_take <= 1'b0;
      int_stack_pc <= 16'h0000;
      int_push_hx <= 1'b0;
    end else begin
      if (stop_wait_in_break) begin
        swb_q <= 1'b1;
      end else if (wr_bstat && !wdata_q[`SIR_BIT_SWB]) begin
        swb_q <= 1'b0;
      end
      if (wr_bctrl) begin
        break_clear_enable_q <= wdata_q[`SIR_BIT_BREAK_CLEAR_ENABLE];
      end
      if (wr_imask) begin
        irq_mask_q <= wdata_q[3:0];
      end
      // Events win over the clearing read
      irq_stat_q <= (rd_istat && clr_ok ? 4'h0 : irq_stat_q) | irq_ev;
      irq_out <= |(irq_stat_q & irq_mask_q);
      flag_clear_allow <= flag_clear_req && clr_ok;
      int_take <= swi_exec || (hw_irq_req && !int_mask);
      int_stack_pc <= swi_exec ? core_pc : core_pc - 16'h0001;
      int_push_hx <= 1'b0;
    end
  end

  // ****************************************
  // AXI4-Lite slave
  // ****************************************
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `SIR_RESP_OKAY;
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= `SIR_RESP_OKAY;
      s_axi_rdata <= 32'h0000_0000;
      awaddr_q <= 16'h0000;
      aw_have_q <= 1'b0;
      wdata_q <= 32'h0000_0000;
      w_have_q <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awaddr_q <= s_axi_awaddr;
        aw_have_q <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_q <= s_axi_wdata;
        w_have_q <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_known ? `SIR_RESP_OKAY : `SIR_RESP_SLVERR;
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
      if (rd_fire) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `SIR_RESP_OKAY;
        s_axi_rdata <= 32'h0000_0000;
        if (hit(s_axi_araddr, `SIR_ADDR_BRK_STAT)) begin
          s_axi_rdata[`SIR_BIT_SWB] <= swb_q;
        end else if (hit(s_axi_araddr, `SIR_ADDR_RST_CAUSE)) begin
          s_axi_rdata[7:0] <= cause_q;
        end else if (hit(s_axi_araddr, `SIR_ADDR_BRK_CTRL)) begin
          s_axi_rdata[`SIR_BIT_BREAK_CLEAR_ENABLE] <= break_clear_enable_q;
        end else if (hit(s_axi_araddr, `SIR_ADDR_IRQ_STAT)) begin
          s_axi_rdata[3:0] <= irq_stat_q;
        end else if (hit(s_axi_araddr, `SIR_ADDR_IRQ_MASK)) begin
          s_axi_rdata[3:0] <= irq_mask_q;
        end else if (!hit(s_axi_araddr, `SIR_ADDR_WDOG_SVC)) begin
          s_axi_rresp <= `SIR_RESP_SLVERR;
        end
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule

// *** bench/sir_props.sv ***
// Port checker for the reset and break control block.
// Assumes a bind to sir_top and a single clock domain.
`timescale 1ns/1ps
module sir_props #(
  parameter STAB_CYCLES = 4096
) (
  input wire clk_sys,
  input wire rst,
  input wire sys_reset,
  input wire rst_pin_oe,
  input wire base_clk_en,
  input wire core_clk_en,
  input wire illegal_opcode,
  input wire swi_exec,
  input wire hw_irq_req,
  input wire int_mask,
  input wire [15:0] core_pc,
  input wire int_take,
  input wire [15:0] int_stack_pc,
  input wire int_push_hx,
  input wire break_active,
  input wire flag_clear_req,
  input wire flag_clear_allow
);
  reg [15:0] stab_q;
  always @(posedge clk_sys or posedge rst) begin
    if (rst)
      stab_q <= 16'h0000;
    else if (!core_clk_en)
      stab_q <= stab_q + 16'h0001;
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  a_base_clk_on: assert property (!$past(rst) |-> base_clk_en)
    else $error("base clock off");
  a_stab_long: assert property ($rose(core_clk_en) |-> stab_q >= STAB_CYCLES)
    else $error("clocks enabled early");
  a_stab_pin: assert property (!core_clk_en |-> rst_pin_oe)
    else $error("pin released early");
  a_swi_pc: assert property (swi_exec && !sys_reset |=>
    int_take && int_stack_pc == $past(core_pc)) else $error("swi stack wrong");
  a_hw_pc: assert property (hw_irq_req && !int_mask && !swi_exec && !sys_reset |=>
    int_take && int_stack_pc == $past(core_pc) - 16'h0001) else $error("hw stack wrong");
  a_no_hx_push: assert property (int_take |-> !int_push_hx)
    else $error("index pushed");
  a_clear_free: assert property (flag_clear_req && !break_active |=> flag_clear_allow)
    else $error("clear blocked");
  a_clear_cause: assert property (flag_clear_allow |-> $past(flag_clear_req))
    else $error("clear without request");
  a_illegal_opcode_cause_reset: assert property (illegal_opcode && !sys_reset |->
    ##[1:3] sys_reset && rst_pin_oe) else $error("no opcode reset");
  c_swi: cover property (swi_exec && int_mask);
  c_reset: cover property ($rose(sys_reset));
  c_brk_clear: cover property (break_active && flag_clear_allow);
endmodule
bind sir_top sir_props #(.STAB_CYCLES(STAB_CYCLES)) i_sir_props (.clk_sys, .rst, .sys_reset,
  .rst_pin_oe, .base_clk_en, .core_clk_en, .illegal_opcode, .swi_exec, .hw_irq_req,
  .int_mask, .core_pc, .int_take, .int_stack_pc, .int_push_hx, .break_active,
  .flag_clear_req, .flag_clear_allow);

// *** bench/sir_far_model.sv ***
// Far side: reset pin with pull-up and a running core counter.
// Assumes the block only ever pulls the pin low.
`timescale 1ns/1ps
module sir_far_model (
  input wire clk_sys,
  input wire rst_pin_out,
  input wire rst_pin_oe,
  output wire rst_pin_in,
  output reg [15:0] core_pc
);
  assign rst_pin_in = rst_pin_oe ? rst_pin_out : 1'b1;
  initial core_pc = 16'h8000;
  always @(posedge clk_sys) begin
    core_pc <= core_pc + 16'h0003;
  end
endmodule

// *** bench/tb_top.sv ***
// Self-checking bench for the reset and break control block.
// Assumes sir_top, sir_far_model and the bound checker.
`timescale 1ns/1ps
module tb_top;
  reg clk_sys, rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  reg rst_pin_hv, interrupt_one_pin_pin_hv, interrupt_one_pin_req, monitor_mode, break_active, stop_wait_in_break;
  reg illegal_opcode, swi_exec, hw_irq_req, int_mask, flag_clear_req;
  reg [15:0] s_axi_awaddr, s_axi_araddr;
  reg [31:0] s_axi_wdata, rd;
  reg [1:0] rsp;
  wire [3:0] s_axi_wstrb = 4'hf;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, rst_pin_in;
  wire rst_pin_out, rst_pin_oe, flag_clear_allow, base_clk_en, core_clk_en, sys_reset;
  wire int_take, int_push_hx, irq_out;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [15:0] core_pc, int_stack_pc;
  integer failures = 0, n_compared = 0, n_rst = 0;
  sir_top #(.STAB_CYCLES(16), .WDOG_W(1)) i_sir_top (.*);
  sir_far_model i_sir_far_model (.clk_sys, .rst_pin_out, .rst_pin_oe, .rst_pin_in, .core_pc);
  always @(posedge sys_reset) n_rst = n_rst + 1;
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      n_compared = n_compared + 1;
      if (seen !== exp) begin
        failures = failures + 1;
        $display("unexpected at %0t: %h vs %h", $time, seen, exp);
      end
    end
  endtask
  task summarize;
    begin
      $display("compared %0d, failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask
  // ***
  // Bus cycles
  // ***
  task wr(input [15:0] a, input [31:0] d);
    reg done;
    begin
      @(posedge clk_sys);
      {s_axi_awaddr, s_axi_wdata} <= {a, d};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      done = 1'b0;
      while (!done) begin
        @(posedge clk_sys);
        if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
        if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        if (s_axi_bvalid) begin
          s_axi_bready <= 1'b0;
          rsp = s_axi_bresp;
          done = 1'b1;
        end
      end
    end
  endtask
  task rdr(input [15:0] a);
    reg done;
    begin
      @(posedge clk_sys);
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'h3;
      done = 1'b0;
      while (!done) begin
        @(posedge clk_sys);
        if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        if (s_axi_rvalid) begin
          s_axi_rready <= 1'b0;
          {rd, rsp} = {s_axi_rdata, s_axi_rresp};
          done = 1'b1;
        end
      end
    end
  endtask
  task rc(input [15:0] a, input [31:0] e);
    begin
      rdr(a);
      chk(rd, e);
    end
  endtask
  task interrupt_one_pin;
    begin
      @(posedge clk_sys);
      interrupt_one_pin_req <= 1'b1;
      repeat (3) @(posedge clk_sys);
      interrupt_one_pin_req <= 1'b0;
      repeat (4) @(posedge clk_sys);
    end
  endtask
  task brk(input b);
    begin
      @(posedge clk_sys);
      break_active <= b;
    end
  endtask
  task fcr(input e);
    begin
      @(posedge clk_sys);
      flag_clear_req <= 1'b1;
      @(posedge clk_sys);
      flag_clear_req <= 1'b0;
      #1 chk(flag_clear_allow, e);
    end
  endtask
  task rel;
    begin
      @(posedge clk_sys);
      while (sys_reset) @(posedge clk_sys);
    end
  endtask
  task pulse_illegal_opcode_cause;
    begin
      @(posedge clk_sys);
      illegal_opcode <= 1'b1;
      @(posedge clk_sys);
      illegal_opcode <= 1'b0;
      repeat (2) @(posedge clk_sys);
    end
  endtask
  // ***
  // Scenarios
  // ***
  task t_por;
    begin
      while (!core_clk_en) @(posedge clk_sys);
      #1 chk({sys_reset, rst_pin_oe, base_clk_en}, 3'h1);
      rc(16'hfe01, 32'h0000_0080);
      rc(16'hfe03, 32'h0000_0000);
      rdr(16'hfe02);
      chk(rsp, 2'h2);
      wr(16'hfe02, 32'h0000_0000);
      chk(rsp, 2'h2);
      @(posedge clk_sys);
      stop_wait_in_break <= 1'b1;
      @(posedge clk_sys);
      stop_wait_in_break <= 1'b0;
      rc(16'hfe00, 32'h0000_0002);
      wr(16'hfe00, 32'h0000_0000);
      chk(rsp, 2'h0);
      rc(16'hfe00, 32'h0000_0000);
    end
  endtask
  task t_brk;
    begin
      wr(16'hfe0c, 32'h0000_0004);
      interrupt_one_pin;
      chk(irq_out, 1'b1);
      brk(1);
      fcr(0);
      rc(16'hfe08, 32'h0000_0004);
      rc(16'hfe08, 32'h0000_0004);
      brk(0);
      fcr(1);
      rc(16'hfe08, 32'h0000_0004);
      rc(16'hfe08, 32'h0000_0000);
      chk(irq_out, 1'b0);
      wr(16'hfe03, 32'h0000_0080);
      interrupt_one_pin;
      brk(1);
      fcr(1);
      rc(16'hfe08, 32'h0000_0004);
      brk(0);
      rc(16'hfe08, 32'h0000_0000);
    end
  endtask
  task t_int;
    integer k;
    reg [15:0] pc;
    begin
      for (k = 0; k < 3; k = k + 1) begin
        @(posedge clk_sys);
        {swi_exec, hw_irq_req, int_mask} <= {k == 0, k != 0, k != 2};
        @(posedge clk_sys);
        pc = core_pc;
        {swi_exec, hw_irq_req} <= 2'h0;
        #1 chk(int_take, k != 1);
        chk(int_push_hx, 1'b0);
        if (k != 1) chk(int_stack_pc, k == 0 ? pc : pc - 16'h0001);
      end
    end
  endtask
  task t_wdog;
    integer k, n0;
    begin
      n0 = n_rst;
      // Service span is shorter than one watchdog tick, but the three spans outlast two, so a dead service would reset
      for (k = 0; k < 3; k = k + 1) begin
        wr(16'hffff, 32'h0000_00a5);
        repeat (7000) @(posedge clk_sys);
      end
      chk(n_rst, n0);
      {monitor_mode, interrupt_one_pin_pin_hv} <= 2'h3;
      repeat (12000) @(posedge clk_sys);
      chk(n_rst, n0);
      {break_active, rst_pin_hv} <= 2'h3;
      repeat (4) @(posedge clk_sys);
      {monitor_mode, interrupt_one_pin_pin_hv} <= 2'h0;
      repeat (18000) @(posedge clk_sys);
      chk(n_rst, n0);
      {break_active, rst_pin_hv} <= 2'h0;
      wait (n_rst != n0);
      repeat (2) @(posedge clk_sys);
      chk({rst_pin_oe, rst_pin_out}, 2'h2);
      rel;
      rc(16'hfe01, 32'h0000_0020);
      pulse_illegal_opcode_cause;
      chk(rst_pin_oe, 1'b1);
      rel;
      rc(16'hfe01, 32'h0000_0010);
    end
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  initial begin
    #400000;
    failures = failures + 1;
    summarize;
  end
  initial begin
    rst = 1'b1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {rst_pin_hv, interrupt_one_pin_pin_hv, interrupt_one_pin_req, monitor_mode, break_active} = 5'h00;
    {stop_wait_in_break, illegal_opcode, swi_exec, hw_irq_req, flag_clear_req} = 5'h00;
    int_mask = 1'b1;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 64'h0000_0000_0000_0000;
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    t_por;
    t_brk;
    t_int;
    t_wdog;
    summarize;
  end
endmodule
